/* core/path_overhead_monitor_counters.sv */
// path overhead monitor: label filter, error counters, diagnostics, wishbone slave
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`include "pohm_cfg.svh"

module path_overhead_monitor_counters (
    input  wire logic                  MCLK_IN,
    input  wire logic                  SRST_IN,
    // classic wishbone slave
    input  wire logic                  WB_CYC_IN,
    input  wire logic                  WB_STB_IN,
    input  wire logic                  WB_WE_IN,
    input  wire logic [9:0]            WB_ADR_IN,
    input  wire logic [3:0]            WB_SEL_IN,
    input  wire logic [31:0]           WB_DAT_IN,
    output logic      [31:0]           WB_DAT_OUT,
    output logic                       WB_ACK_OUT,
    output logic                       IRQ_OUT,
    // receive side; the frame summary is qualified by the frame pulse, pointer indications are not
    input  wire logic                  FRAME_IN,
    input  wire pohm_pkg::rx_frame_type RX_FRAME_IN,
    input  wire pohm_pkg::ptr_ind_type PTR_IND_IN,
    output pohm_pkg::ptr_ind_type      PTR_IND_OUT,
    output logic      [3:0]            PAR_REPORT_OUT,
    output logic                       PAR_REPORT_VALID_OUT,
    // transmit side
    input  wire logic                  TX_VALID_IN,
    input  wire pohm_pkg::tx_byte_type TX_BYTE_IN,
    input  wire logic [2:0]            RDI_ALARM_IN,
    output logic                       TX_VALID_OUT,
    output logic      [7:0]            TX_DATA_OUT
);
    import pohm_pkg::*;

    // number of set bits in a parity mismatch byte
    function automatic logic [3:0] pop8(input logic [7:0] v);
        logic [3:0] n;
        n = 4'd0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'd0, v[i]};
        end
        return n;
    endfunction

    // add without wrapping past all ones
    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [3:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {13'd0, b};
        return s[16] ? 16'hFFFF : s[15:0];
    endfunction

    // registers
    bus_state_type bus_q;
    logic [7:0]  label_q;
    logic [7:0]  hist_q [0:`LABEL_DEPTH-2];
    logic [15:0] par_acc_q, par_hold_q, fe_acc_q, fe_hold_q;
    logic [7:0]  rdi_ctrl_q, ring_q, diag_q, irq_st_q, irq_mask_q;
    logic        ardi_q;
    logic [2:0]  ardi_cnt_q;
    logic [1:0]  spacing_q;
    logic [4:0]  hold_cnt_q;
    logic [2:0]  hold_code_q;

    // bus decode
    wire         bus_req   = WB_CYC_IN & WB_STB_IN & (bus_q == BUS_IDLE);
    wire         wr_en     = bus_req & WB_WE_IN & WB_SEL_IN[0];
    wire  [7:0]  idx       = WB_ADR_IN[9:2];
    wire  [7:0]  wdat      = WB_DAT_IN[7:0];
    wire         wr_rdi    = wr_en & (idx == `IDX_RDI_CTRL);
    wire         wr_ring   = wr_en & (idx == `IDX_RING_CTRL);
    wire         wr_diag   = wr_en & (idx == `IDX_TX_DIAG);
    wire         wr_irq_st = wr_en & (idx == `IDX_IRQ_STATUS);
    wire         wr_mask   = wr_en & (idx == `IDX_IRQ_MASK);
    // any write to the four count addresses or the master reset polls
    wire         poll = wr_en & ((idx == `IDX_MASTER_RESET) |
                                 (idx >= `IDX_PAR_LO && idx <= `IDX_FE_HI));

    // mode bits
    wire fe_block    = rdi_ctrl_q[`BIT_FE_BLOCK];
    wire ardi_irq_en = irq_mask_q[`IRQ_ARDI];
    wire spacing_en  = ring_q[`BIT_SPACING];
    wire size_chk    = ring_q[`BIT_SIZE_CHECK];
    wire par_blk_acc = ring_q[`BIT_PAR_BLK_ACC];
    wire par_blk_rep = ring_q[`BIT_PAR_BLK_REP];
    wire enh_rdi     = diag_q[`BIT_ENH_RDI_EN];
    wire rdi_hold    = diag_q[`BIT_RDI_HOLD];
    wire corrupt_par = diag_q[`BIT_CORRUPT_PAR];
    wire force_alarm = diag_q[`BIT_FORCE_ALARM];

    // label filter: the new label and the previous four frames vote
    // an equal label never re-takes, so no spurious label-change event
    logic [2:0] label_hits;
    always_comb begin
        label_hits = 3'd1;
        for (int i = 0; i < `LABEL_DEPTH - 1; i++) begin
            label_hits = label_hits + {2'd0, hist_q[i] == RX_FRAME_IN.label};
        end
    end
    wire label_take = FRAME_IN & (label_hits >= 3'(`LABEL_NEED))
                      & (RX_FRAME_IN.label != label_q);

    // per-frame increments
    // far-end codes above eight are invalid and add nothing in either mode
    wire [3:0] par_bits = pop8(RX_FRAME_IN.parity_xor);
    wire       par_any  = |RX_FRAME_IN.parity_xor;
    wire [3:0] par_inc  = !FRAME_IN ? 4'd0 :
                          par_blk_acc ? {3'd0, par_any} : par_bits;
    wire [3:0] par_rep  = par_blk_rep ? {3'd0, par_any} : par_bits;
    wire       fe_ok    = RX_FRAME_IN.far_end_code <= `FE_MAX_CODE;
    wire       fe_any   = fe_ok & (RX_FRAME_IN.far_end_code != 4'd0);
    wire [3:0] fe_inc   = !FRAME_IN ? 4'd0 :
                          fe_block ? {3'd0, fe_any} :
                          (fe_ok ? RX_FRAME_IN.far_end_code : 4'd0);
    wire [15:0] par_sum = sat_add(par_acc_q, par_inc);
    wire [15:0] fe_sum  = sat_add(fe_acc_q, fe_inc);

    // aux defect filter, five equal frames move the state
    // only the five-frame window is built; the 3-bit count would also hold six or seven, longer needs a wider count
    wire [2:0] ardi_next = ardi_cnt_q + 3'd1;
    wire       ardi_flip = FRAME_IN & (RX_FRAME_IN.aux_rdi != ardi_q)
                           & (ardi_next == `ARDI_FRAMES);

    // pointer qualification
    // spacing saturates at three, so a long quiet spell never wraps round
    wire ss_ok  = !size_chk || (PTR_IND_IN.size_bits == `SS_EXPECTED);
    wire sp_ok  = !spacing_en || (spacing_q >= `SPACING_FRAMES);
    wire q_ndf  = PTR_IND_IN.new_data_flag_enabled & ss_ok;
    wire q_inc  = PTR_IND_IN.inc_ind & ss_ok & sp_ok;
    wire q_dec  = PTR_IND_IN.dec_ind & ss_ok & sp_ok;
    wire q_newp = PTR_IND_IN.new_point & ss_ok;
    wire offset_change = q_ndf | q_inc | q_dec;

    // transmitted defect code
    // the hold timer counts receive frames, the only frame marker seen here
    wire       alarm_on = RDI_ALARM_IN != 3'd0;
    wire [2:0] rdi_code = !rdi_hold ? RDI_ALARM_IN :
                          alarm_on ? RDI_ALARM_IN :
                          (hold_cnt_q != 5'd0) ? hold_code_q : 3'd0;
    wire [7:0] g1_out   = enh_rdi ? {rdi_code, TX_BYTE_IN.data[4:0]} :
                          {TX_BYTE_IN.data[7:6], rdi_code[0], TX_BYTE_IN.data[4:0]};
    wire [7:0] tx_next  = (force_alarm & TX_BYTE_IN.is_ptr_or_spe) ? 8'hFF :
                          (corrupt_par & TX_BYTE_IN.is_parity) ? ~TX_BYTE_IN.data :
                          TX_BYTE_IN.is_g1 ? g1_out : TX_BYTE_IN.data;

    // interrupt events; a set in the clearing cycle wins
    // status bits mark frames, not single errors, to bound the event rate
    wire [7:0] irq_ev = {4'd0, fe_inc != 4'd0, par_inc != 4'd0, label_take,
                         ardi_flip};
    wire [7:0] irq_st_d = (irq_st_q & ~(wr_irq_st ? wdat : 8'h00)) | irq_ev;

    // read mux
    logic [7:0] rd_byte;
    always_comb begin
        case (idx)
            `IDX_RX_LABEL:   rd_byte = label_q;
            `IDX_PAR_LO:     rd_byte = par_hold_q[7:0];
            `IDX_PAR_HI:     rd_byte = par_hold_q[15:8];
            `IDX_FE_LO:      rd_byte = fe_hold_q[7:0];
            `IDX_FE_HI:      rd_byte = fe_hold_q[15:8];
            `IDX_RDI_CTRL:   rd_byte = {rdi_ctrl_q[7:2], ardi_irq_en, ardi_q};
            `IDX_RING_CTRL:  rd_byte = ring_q;
            `IDX_TX_DIAG:    rd_byte = diag_q;
            `IDX_IRQ_STATUS: rd_byte = irq_st_q;
            `IDX_IRQ_MASK:   rd_byte = irq_mask_q;
            default:         rd_byte = 8'h00;
        endcase
    end

    // wishbone handshake: ack one cycle after the strobe, dropped next cycle
    // read data is latched with ack and held until the next request
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            bus_q      <= BUS_IDLE;
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= 32'h0000_0000;
        end else begin
            WB_ACK_OUT <= bus_req;
            bus_q      <= bus_req ? BUS_ACK : BUS_IDLE;
            if (bus_req) begin
                WB_DAT_OUT <= {24'h00_0000, rd_byte};
            end
        end
    end

    // control registers; reserved fields are masked off on write, except in ring control where all bits are stored as written
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            rdi_ctrl_q <= `RST_BYTE;
            ring_q     <= `RST_BYTE;
            diag_q     <= `RST_BYTE;
            irq_mask_q <= `RST_BYTE;
            irq_st_q   <= `RST_BYTE;
            IRQ_OUT    <= 1'b0;
        end else begin
            if (wr_rdi) begin
                rdi_ctrl_q <= wdat & `RDI_CTRL_WMASK;
            end
            if (wr_ring) begin
                ring_q <= wdat;
            end
            if (wr_diag) begin
                diag_q <= wdat & `TX_DIAG_WMASK;
            end
            // the aux enable is one flop seen at two addresses
            if (wr_mask) begin
                irq_mask_q <= wdat & `IRQ_WMASK;
            end else if (wr_rdi) begin
                irq_mask_q[`IRQ_ARDI] <= wdat[`BIT_ARDI_IRQ_EN];
            end
            irq_st_q <= irq_st_d & `IRQ_WMASK;
            IRQ_OUT  <= |(irq_st_d & irq_mask_q);
        end
    end

    // label history and filtered label
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            label_q <= 8'h00;
            for (int i = 0; i < `LABEL_DEPTH - 1; i++) begin
                hist_q[i] <= 8'h00;
            end
        end else if (FRAME_IN) begin
            hist_q[0] <= RX_FRAME_IN.label;
            for (int i = 1; i < `LABEL_DEPTH - 1; i++) begin
                hist_q[i] <= hist_q[i-1];
            end
            if (label_take) begin
                label_q <= RX_FRAME_IN.label;
            end
        end
    end

    // accumulators: a poll folds this cycle's event into the latched count
    // the transfer takes one cycle, far inside the allowed poll time
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            par_acc_q  <= 16'h0000;
            par_hold_q <= 16'h0000;
            fe_acc_q   <= 16'h0000;
            fe_hold_q  <= 16'h0000;
        end else if (poll) begin
            par_hold_q <= par_sum;
            fe_hold_q  <= fe_sum;
            par_acc_q  <= 16'h0000;
            fe_acc_q   <= 16'h0000;
        end else begin
            par_acc_q <= par_sum;
            fe_acc_q  <= fe_sum;
        end
    end

    // aux defect filter
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            ardi_q     <= 1'b0;
            ardi_cnt_q <= 3'd0;
        end else if (FRAME_IN) begin
            if (RX_FRAME_IN.aux_rdi == ardi_q || ardi_flip) begin
                ardi_cnt_q <= 3'd0;
            end else begin
                ardi_cnt_q <= ardi_next;
            end
            if (ardi_flip) begin
                ardi_q <= RX_FRAME_IN.aux_rdi;
            end
        end
    end

    // pointer indications and frames since the last offset change
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            spacing_q   <= 2'd0;
            PTR_IND_OUT <= '0;
        end else begin
            PTR_IND_OUT <= {PTR_IND_IN.size_bits, q_ndf, q_inc, q_dec, q_newp};
            if (offset_change) begin
                spacing_q <= 2'd0;
            end else if (FRAME_IN && spacing_q != `SPACING_FRAMES) begin
                spacing_q <= spacing_q + 2'd1;
            end
        end
    end

    // parity report toward the transmit overhead logic
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            PAR_REPORT_OUT       <= 4'd0;
            PAR_REPORT_VALID_OUT <= 1'b0;
        end else begin
            PAR_REPORT_VALID_OUT <= FRAME_IN;
            if (FRAME_IN) begin
                PAR_REPORT_OUT <= par_rep;
            end
        end
    end

    // defect hold timer, counted in receive frames
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            hold_cnt_q  <= 5'd0;
            hold_code_q <= 3'd0;
        end else if (FRAME_IN) begin
            if (alarm_on) begin
                hold_cnt_q  <= `HOLD_FRAMES;
                hold_code_q <= RDI_ALARM_IN;
            end else if (hold_cnt_q != 5'd0) begin
                hold_cnt_q <= hold_cnt_q - 5'd1;
            end
        end
    end

    // transmit byte path, one cycle of latency
    // forced alarm outranks parity corruption since it overwrites B3 as well
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN) begin
            TX_VALID_OUT <= 1'b0;
            TX_DATA_OUT  <= 8'h00;
        end else begin
            TX_VALID_OUT <= TX_VALID_IN;
            TX_DATA_OUT  <= tx_next;
        end
    end
endmodule

/* core/pohm_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef POHM_CFG_SVH
`define POHM_CFG_SVH
// register indices; byte address is four times the index
`define IDX_MASTER_RESET   8'h00
`define IDX_RX_LABEL       8'h37
`define IDX_PAR_LO         8'h38
`define IDX_PAR_HI         8'h39
`define IDX_FE_LO          8'h3A
`define IDX_FE_HI          8'h3B
`define IDX_RDI_CTRL       8'h3C
`define IDX_RING_CTRL      8'h3D
`define IDX_TX_DIAG        8'h40
`define IDX_IRQ_STATUS     8'h50
`define IDX_IRQ_MASK       8'h51
// remote defect control fields
`define BIT_FE_BLOCK       4
`define BIT_ARDI_IRQ_EN    1
`define BIT_ARDI_STATE     0
`define RDI_CTRL_WMASK     8'h36
// ring control fields
`define BIT_SPACING        7
`define BIT_SIZE_CHECK     6
`define BIT_PAR_BLK_ACC    5
`define BIT_PAR_BLK_REP    3
// transmit diagnostic fields
`define BIT_ENH_RDI_EN     6
`define BIT_ENH_RDI_SRC    5
`define BIT_RDI_HOLD       4
`define BIT_CORRUPT_PAR    1
`define BIT_FORCE_ALARM    0
`define TX_DIAG_WMASK      8'h7F
// interrupt status bits
`define IRQ_ARDI           0
`define IRQ_LABEL          1
`define IRQ_PARITY         2
`define IRQ_FAR_END        3
`define IRQ_WMASK          8'h0F
`define RST_BYTE           8'h00
// label filter, aux defect filter, spacing, hold
`define LABEL_DEPTH        5
`define LABEL_NEED         3
`define ARDI_FRAMES        3'd5
`define SPACING_FRAMES     2'd3
`define HOLD_FRAMES        5'd20
`define SS_EXPECTED        2'b10
`define FE_MAX_CODE        4'd8
// poll transfer limit
`define CLK_MHZ            25
`define POLL_TIME_US       7
`define POLL_MAX_CYC       (`POLL_TIME_US * `CLK_MHZ)
`endif

/* core/pohm_pkg.sv */
// types shared by the path overhead monitor
package pohm_pkg;
    // per-frame receive overhead summary from the line processor
    typedef struct packed {
        logic [7:0] label;
        logic [7:0] parity_xor;
        logic [3:0] far_end_code;
        logic       aux_rdi;
    } rx_frame_type;
    // pointer interpreter indications
    typedef struct packed {
        logic [1:0] size_bits;
        logic       new_data_flag_enabled;
        logic       inc_ind;
        logic       dec_ind;
        logic       new_point;
    } ptr_ind_type;
    // transmit byte with its position markers
    typedef struct packed {
        logic [7:0] data;
        logic       is_ptr_or_spe;
        logic       is_parity;
        logic       is_g1;
    } tx_byte_type;
    typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_type;
endpackage

/* test/pohm_line_model.sv */
// upstream line processor model: frame pulses carrying the overhead summary
`timescale 1ns/10ps
module pohm_line_model (
    input  wire logic                   clk_in,
    input  wire logic                   srst_in,
    input  wire logic                   send_in,
    input  wire pohm_pkg::rx_frame_type frame_in,
    output logic                        frame_out,
    output pohm_pkg::rx_frame_type      rx_out
);
    import pohm_pkg::*;
    // between pulses the summary toggles, so stale data never looks valid
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            frame_out <= 1'b0;
            rx_out    <= '0;
        end else begin
            frame_out <= send_in;
            rx_out    <= send_in ? frame_in : ~rx_out;
        end
    end
endmodule

/* test/pohm_chk.sv */
// port assertions for the path overhead monitor
`timescale 1ns/10ps
`include "pohm_cfg.svh"
module pohm_chk (
    input wire logic                   MCLK_IN,
    input wire logic                   SRST_IN,
    input wire logic                   WB_CYC_IN,
    input wire logic                   WB_STB_IN,
    input wire logic                   WB_WE_IN,
    input wire logic [9:0]             WB_ADR_IN,
    input wire logic [3:0]             WB_SEL_IN,
    input wire logic [31:0]            WB_DAT_IN,
    input wire logic [31:0]            WB_DAT_OUT,
    input wire logic                   WB_ACK_OUT,
    input wire logic                   FRAME_IN,
    input wire pohm_pkg::ptr_ind_type  PTR_IND_IN,
    input wire pohm_pkg::ptr_ind_type  PTR_IND_OUT,
    input wire logic [3:0]             PAR_REPORT_OUT,
    input wire logic                   PAR_REPORT_VALID_OUT,
    input wire pohm_pkg::tx_byte_type  TX_BYTE_IN,
    input wire logic [7:0]             TX_DATA_OUT
);
    import pohm_pkg::*;
    logic [7:0] diag_q;
    logic [7:0] ring_q;
    // shadow of the mode registers, taken on the same edge as the slave
    wire wr_take = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !WB_ACK_OUT && WB_SEL_IN[0];
    wire plain   = TX_BYTE_IN[2:0] == 3'b000;
    wire g1_only = TX_BYTE_IN[2:0] == 3'b001;
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN)
            diag_q <= 8'h00;
        else if (wr_take && WB_ADR_IN[9:2] == `IDX_TX_DIAG)
            diag_q <= WB_DAT_IN[7:0];
    end
    always_ff @(posedge MCLK_IN) begin
        if (SRST_IN)
            ring_q <= 8'h00;
        else if (wr_take && WB_ADR_IN[9:2] == `IDX_RING_CTRL)
            ring_q <= WB_DAT_IN[7:0];
    end
    wire alarm_on = diag_q[`BIT_FORCE_ALARM];
    wire flip_on  = diag_q[`BIT_CORRUPT_PAR] && !(TX_BYTE_IN.is_ptr_or_spe && alarm_on);
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SRST_IN);
    sequence s_req;
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    endsequence
    sequence s_ack_pulse;
        WB_ACK_OUT ##1 !WB_ACK_OUT;
    endsequence
    a_ack_timing: assert property (s_req |=> s_ack_pulse)
        else $error("ack not a single pulse one cycle after request");
    a_ack_cause: assert property (WB_ACK_OUT |-> $past(WB_STB_IN && WB_CYC_IN))
        else $error("ack without request");
    a_read_upper: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_report_range: assert property (PAR_REPORT_VALID_OUT |-> $past(FRAME_IN) && PAR_REPORT_OUT <= 4'h8)
        else $error("parity report out of range or untimed");
    a_alarm_ones: assert property (TX_BYTE_IN.is_ptr_or_spe && alarm_on |=> TX_DATA_OUT == 8'hFF)
        else $error("forced alarm byte not all ones");
    a_parity_flip: assert property (TX_BYTE_IN.is_parity && flip_on |=> TX_DATA_OUT == ~$past(TX_BYTE_IN.data))
        else $error("parity byte not inverted");
    a_plain_pass: assert property (plain |=> TX_DATA_OUT == $past(TX_BYTE_IN.data))
        else $error("plain byte altered");
    a_g1_basic: assert property (g1_only && !diag_q[`BIT_ENH_RDI_EN] |=> TX_DATA_OUT[7:6] == $past(TX_BYTE_IN.data[7:6]))
        else $error("basic mode altered upper g1 bits");
    a_size_gate: assert property (ring_q[`BIT_SIZE_CHECK] && PTR_IND_IN.size_bits != `SS_EXPECTED |=> PTR_IND_OUT[3:0] == 4'h0)
        else $error("pointer indication passed with wrong size bits");
endmodule
bind path_overhead_monitor_counters pohm_chk u_chk (
    .MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
    .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
    .FRAME_IN(FRAME_IN), .PTR_IND_IN(PTR_IND_IN), .PTR_IND_OUT(PTR_IND_OUT),
    .PAR_REPORT_OUT(PAR_REPORT_OUT), .PAR_REPORT_VALID_OUT(PAR_REPORT_VALID_OUT),
    .TX_BYTE_IN(TX_BYTE_IN), .TX_DATA_OUT(TX_DATA_OUT));

/* test/path_overhead_monitor_counters_bench.sv */
// self-checking bench for the path overhead monitor
`timescale 1ns/10ps
module path_overhead_monitor_counters_bench;
    import pohm_pkg::*;
    logic         clk = 1'b0;
    logic         srst = 1'b1;
    logic         cyc = 1'b0;
    logic         stb = 1'b0;
    logic         we = 1'b0;
    logic [9:0]   adr = 10'h000;
    logic [3:0]   sel = 4'h0;
    logic [31:0]  wdat = 32'h0000_0000;
    logic [31:0]  rdat;
    logic [31:0]  rd;
    logic         ack;
    logic         irq;
    logic         send = 1'b0;
    logic         frame;
    rx_frame_type fdat = '0;
    rx_frame_type rx;
    ptr_ind_type  ptr_in = '0;
    ptr_ind_type  ptr_out;
    tx_byte_type  txb = '0;
    logic [7:0]   txd;
    logic [3:0]   rep;
    logic [2:0]   alarm = 3'h0;
    logic         txv = 1'b0;
    logic         txv_out;
    int           failures = 0;
    int           tests_run = 0;
    // 25 MHz byte clock
    always #20 clk = ~clk;
    path_overhead_monitor_counters u_dut (
        .MCLK_IN(clk), .SRST_IN(srst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .IRQ_OUT(irq), .FRAME_IN(frame), .RX_FRAME_IN(rx),
        .PTR_IND_IN(ptr_in), .PTR_IND_OUT(ptr_out), .PAR_REPORT_OUT(rep),
        .PAR_REPORT_VALID_OUT(), .TX_VALID_IN(txv), .TX_BYTE_IN(txb),
        .RDI_ALARM_IN(alarm), .TX_VALID_OUT(txv_out), .TX_DATA_OUT(txd));
    pohm_line_model u_line (
        .clk_in(clk), .srst_in(srst), .send_in(send), .frame_in(fdat),
        .frame_out(frame), .rx_out(rx));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; ack and read data are taken at the same edge
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= {idx, 2'b00};
        wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        check(rd, {24'h00_0000, exp});
    endtask
    // frames from the line model, four cycles apart
    task automatic frames(input rx_frame_type f, input int n);
        fdat <= f;
        repeat (n) begin
            send <= 1'b1;
            @(posedge clk);
            send <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask
    task automatic t_regs();
        logic [7:0] idx [9] = '{8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h40, 8'h7F};
        foreach (idx[i]) rdchk(idx[i], 8'h00);
        wb(1'b1, 8'h3D, 8'hE8);
        rdchk(8'h3D, 8'hE8);
        wb(1'b1, 8'h40, 8'h72);
        rdchk(8'h40, 8'h72);
        wb(1'b1, 8'h3C, 8'h12);
        rdchk(8'h3C, 8'h12);
        wb(1'b1, 8'h7F, 8'hFF);
        rdchk(8'h7F, 8'h00);
        wb(1'b1, 8'h3D, 8'h00);
        wb(1'b1, 8'h40, 8'h00);
        wb(1'b1, 8'h3C, 8'h00);
        $display("test regs done");
    endtask
    task automatic t_label();
        rx_frame_type f = '{label: 8'h5A, default: '0};
        frames(f, 2);
        rdchk(8'h37, 8'h00);
        frames(f, 1);
        rdchk(8'h37, 8'h5A);
        rdchk(8'h50, 8'h02);
        check(irq, 1'b0);
        wb(1'b1, 8'h51, 8'h02);
        check(irq, 1'b1);
        wb(1'b1, 8'h50, 8'h02);
        check(irq, 1'b0);
        wb(1'b1, 8'h51, 8'h00);
        $display("test label done");
    endtask
    task automatic t_parity();
        rx_frame_type f = '{parity_xor: 8'h0B, default: '0};
        frames(f, 3);
        check(rep, 4'h3);
        wb(1'b1, 8'h38, 8'h00);
        rdchk(8'h38, 8'h09);
        rdchk(8'h39, 8'h00);
        wb(1'b1, 8'h3D, 8'h28);
        frames(f, 2);
        check(rep, 4'h1);
        wb(1'b1, 8'h3B, 8'h00);
        rdchk(8'h38, 8'h02);
        wb(1'b1, 8'h3D, 8'h00);
        f.parity_xor = 8'hFF;
        frames(f, 8200);
        wb(1'b1, 8'h39, 8'h00);
        rdchk(8'h38, 8'hFF);
        rdchk(8'h39, 8'hFF);
        // a frame lands on the very edge of the poll write
        fdat <= f;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        wb(1'b1, 8'h38, 8'h00);
        rdchk(8'h38, 8'h08);
        wb(1'b1, 8'h38, 8'h00);
        rdchk(8'h38, 8'h00);
        rdchk(8'h50, 8'h06);
        wb(1'b1, 8'h50, 8'h0F);
        $display("test parity done");
    endtask
    task automatic t_far();
        rx_frame_type f = '{far_end_code: 4'h5, default: '0};
        frames(f, 2);
        f.far_end_code = 4'h9;
        frames(f, 1);
        wb(1'b1, 8'h00, 8'h00);
        rdchk(8'h3A, 8'h0A);
        rdchk(8'h3B, 8'h00);
        wb(1'b1, 8'h3C, 8'h10);
        frames(f, 1);
        f.far_end_code = 4'h8;
        frames(f, 1);
        f.far_end_code = 4'h1;
        frames(f, 1);
        wb(1'b1, 8'h3A, 8'h00);
        rdchk(8'h3A, 8'h02);
        wb(1'b1, 8'h3C, 8'h00);
        rdchk(8'h50, 8'h08);
        wb(1'b1, 8'h50, 8'h0F);
        $display("test far end done");
    endtask
    task automatic t_aux();
        rx_frame_type f = '{aux_rdi: 1'b1, default: '0};
        wb(1'b1, 8'h3C, 8'h02);
        frames(f, 4);
        rdchk(8'h3C, 8'h02);
        frames(f, 1);
        rdchk(8'h3C, 8'h03);
        check(irq, 1'b1);
        wb(1'b1, 8'h50, 8'h01);
        check(irq, 1'b0);
        f.aux_rdi = 1'b0;
        frames(f, 5);
        rdchk(8'h3C, 8'h02);
        check(irq, 1'b1);
        wb(1'b1, 8'h50, 8'h01);
        wb(1'b1, 8'h3C, 8'h00);
        $display("test aux defect done");
    endtask
    task automatic t_tx();
        logic [10:0] b [3] = '{11'h1E4, 11'h1E2, 11'h1E0};
        logic [7:0]  e [3] = '{8'hFF, 8'hC3, 8'h3C};
        wb(1'b1, 8'h40, 8'h03);
        foreach (b[i]) begin
            txb <= b[i];
            repeat (2) @(posedge clk);
            check(txd, e[i]);
        end
        wb(1'b1, 8'h40, 8'h00);
        wb(1'b1, 8'h3D, 8'h40);
        ptr_in <= 6'h0F;
        repeat (2) @(posedge clk);
        check(ptr_out[3:0], 4'h0);
        wb(1'b1, 8'h3D, 8'hC0);
        ptr_in <= 6'h24;
        repeat (2) @(posedge clk);
        check(ptr_out[3:0], 4'h4);
        @(posedge clk);
        check(ptr_out[3:0], 4'h0);
        ptr_in <= 6'h00;
        wb(1'b1, 8'h3D, 8'h00);
        $display("test transmit done");
    endtask
    // defect code insertion into the G1 byte and its hold timer
    task automatic t_rdi();
        rx_frame_type f = '0;
        txb <= 11'h001;
        txv <= 1'b1;
        alarm <= 3'h5;
        repeat (2) @(posedge clk);
        check(txv_out, 1'b1);
        check(txd, 8'h20);
        wb(1'b1, 8'h40, 8'h40);
        check(txd, 8'hA0);
        frames(f, 1);
        alarm <= 3'h0;
        repeat (2) @(posedge clk);
        check(txd, 8'h00);
        wb(1'b1, 8'h40, 8'h50);
        alarm <= 3'h5;
        frames(f, 1);
        alarm <= 3'h0;
        frames(f, 19);
        check(txd, 8'hA0);
        frames(f, 1);
        check(txd, 8'h00);
        wb(1'b1, 8'h40, 8'h00);
        txb <= 11'h000;
        txv <= 1'b0;
        $display("test defect code done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // reset for ten cycles, then the scenarios in turn
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_label();
        t_parity();
        t_far();
        t_aux();
        t_tx();
        t_rdi();
        test_done();
    end
    // watchdog well beyond the roughly 33000 cycles the scenarios take
    initial begin
        #(40 * 60000);
        failures++;
        test_done();
    end
endmodule
